//--- verilog/mgr_regs.svh
// offsets, field positions, reset values and limits of the magnetometer readout
`ifndef MGR_REGS_SVH
`define MGR_REGS_SVH

// register offsets
`define MGR_ADDR_ID 8'h00
`define MGR_ADDR_ST_LO 8'h10
`define MGR_ADDR_ST_HI 8'h1f
`define MGR_ADDR_SET_LO 8'h20
`define MGR_ADDR_SET_HI 8'h27

// status word layout
`define MGR_ST_RESET 16'hfc00
`define MGR_ST_ONES 6'h3f
`define MGR_ST_READY 0
`define MGR_ST_X1 1
`define MGR_ST_X2 2
`define MGR_ST_Y1 3
`define MGR_ST_Y2 4
`define MGR_ST_Z1 5
`define MGR_ST_Z2 6
`define MGR_ST_SENS 7
`define MGR_ST_ADC 8
`define MGR_ST_OVR 9

// result limits on the 18-bit raw converter value
`define MGR_FULL_MAX 18'h0_7fff
`define MGR_FULL_MIN 18'h3_8000
`define MGR_WIDE_MAX 18'h0_2c00
`define MGR_WIDE_MIN 18'h3_d400

// reset value of an axis result
`define MGR_RESULT_RESET 16'h0000

`endif

//--- verilog/mgr_pkg.sv
// types of the magnetometer readout
package mgr_pkg;
  typedef logic [15:0] mgr_word_t;
  typedef logic signed [17:0] mgr_raw_t;
  typedef enum logic [3:0] {
    MGR_PWR_DOWN = 4'b0000,
    MGR_SINGLE = 4'b0001,
    MGR_CONT1 = 4'b0010,
    MGR_CONT2 = 4'b0100,
    MGR_CONT3 = 4'b0110,
    MGR_CONT4 = 4'b1000,
    MGR_CONT5 = 4'b1010,
    MGR_CONT6 = 4'b1100,
    MGR_CONT7 = 4'b1110
  } mgr_mode_e;
endpackage : mgr_pkg

//--- verilog/mgr_axis.sv
// one axis: clamp of the raw value, result register and two switch flags
`timescale 1ns/1ps
`include "mgr_regs.svh"
module mgr_axis #(
  parameter int RAW_W = 18
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic meas_stb,
  input wire logic signed [RAW_W-1:0] raw,
  input wire logic signed [RAW_W-1:0] lim_max,
  input wire logic signed [RAW_W-1:0] lim_min,
  input wire logic signed [15:0] op1,
  input wire logic signed [15:0] rel1,
  input wire logic signed [15:0] op2,
  input wire logic signed [15:0] rel2,
  output logic signed [15:0] result,
  output logic over,
  output logic sw1,
  output logic sw2
);
  import mgr_pkg::*;

  logic signed [RAW_W-1:0] clamped;
  logic signed [15:0] next_result;

  // clamp to the active range and flag the excess
  always_comb begin
    over = 1'b0;
    clamped = raw;
    if (raw > lim_max) begin
      clamped = lim_max;
      over = 1'b1;
    end else if (raw < lim_min) begin
      clamped = lim_min;
      over = 1'b1;
    end
    next_result = clamped[15:0];
  end

  // result register, only a measurement changes it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result <= `MGR_RESULT_RESET; // R18
    end else if (meas_stb) begin
      result <= next_result;
    end
  end

  // level 1 switch: operate sets, release clears, in between holds
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sw1 <= 1'b0;
    end else if (meas_stb) begin
      if (next_result >= op1) begin
        sw1 <= 1'b1; // R6
      end else if (next_result <= rel1) begin
        sw1 <= 1'b0; // R6
      end
    end
  end

  // level 2 switch, same hysteresis
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sw2 <= 1'b0;
    end else if (meas_stb) begin
      if (next_result >= op2) begin
        sw2 <= 1'b1; // R7
      end else if (next_result <= rel2) begin
        sw2 <= 1'b0; // R7
      end
    end
  end
endmodule : mgr_axis

//--- verilog/mgr_rdmux.sv
// read word selection for identification, status and result reads
`timescale 1ns/1ps
`include "mgr_regs.svh"
module mgr_rdmux (
  input wire logic clk,
  input wire logic rst,
  input wire logic rd_stb,
  input wire logic [7:0] addr,
  input wire logic [1:0] idx,
  input wire logic [15:0] id_word,
  input wire logic [15:0] status,
  input wire logic [15:0] res_x,
  input wire logic [15:0] res_y,
  input wire logic [15:0] res_z,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic is_axis
);
  import mgr_pkg::*;

  logic [15:0] res [3];
  logic [15:0] word;
  logic hit;
  logic [1:0] n;

  assign res[0] = res_x;
  assign res[1] = res_y;
  assign res[2] = res_z;

  // status first, then the axes chosen by the low address bits, z before y before x
  always_comb begin
    word = 16'h0000;
    hit = 1'b0;
    n = 2'd0;
    if (addr == `MGR_ADDR_ID) begin
      word = (idx == 2'd0) ? id_word : 16'h0000; // reserved word reads zero
    end else if (addr >= `MGR_ADDR_ST_LO && addr <= `MGR_ADDR_ST_HI) begin
      if (idx == 2'd0) begin
        word = status;
      end else begin
        for (int a = 2; a >= 0; a--) begin
          if (addr[a]) begin
            n = n + 2'd1;
            if (n == idx) begin
              word = res[a];
              hit = 1'b1;
            end
          end
        end
      end
    end
  end

  assign is_axis = rd_stb & hit;

  // registered read data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= 16'h0000;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_stb;
      if (rd_stb) begin
        rd_data <= word;
      end
    end
  end
endmodule : mgr_rdmux

//--- verilog/mgr_readout.sv
// magnetometer status and result readout, top level
//
// What this block does
// (R1) Identification word at 00h: low byte part code, high byte maker code.
// (R2) Ready flag sets when a result lands in single or continuous mode.
// (R3) Ready flag clears on any axis result read or a 20h-27h setting access.
// (R4) In continuous modes overrun sets when an unread result is replaced.
// (R5) Overrun returns to zero once a following measurement replaces no unread result.
// (R6) Per axis level 1 switch: operate threshold sets, release threshold clears.
// (R7) Per axis level 2 switch: operate threshold sets, release threshold clears.
// (R8) Sensor overflow flag follows X or Y overflow, zero otherwise.
// (R9) Converter overflow flag marks the reported results as invalid.
// (R10) Results are 16-bit two's complement, low byte in bits 7:0.
// (R11) High sensitivity: every axis spans -32768 to 32767.
// (R12) Wide range: X and Y are limited to -11264 to 11264.
// (R13) Wide range: Z keeps the full -32768 to 32767 span.
// (R14) Status reads at every address 10h-1fh; low byte resets to zero.
// (R15) The external reset pin returns every register to reset value.
// (R16) Status bits 15:10 read one; status resets to fc00.
// (R17) Out-of-range X or Y is clamped to the limit and flagged.
// (R18) Results reset to zero; read-only registers ignore host writes.
`timescale 1ns/1ps
`include "mgr_regs.svh"
module mgr_readout #(
  parameter logic [7:0] PART_CODE = 8'h5a, // arbitrary value
  parameter logic [7:0] MAKER_CODE = 8'h3c, // arbitrary value
  parameter int RAW_W = 18
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire mgr_pkg::mgr_mode_e MODE,
  input wire logic WIDE_RANGE,
  input wire logic MEAS_STB,
  input wire logic signed [RAW_W-1:0] MEAS_X,
  input wire logic signed [RAW_W-1:0] MEAS_Y,
  input wire logic signed [RAW_W-1:0] MEAS_Z,
  input wire logic MEAS_ADC_OVF,
  input wire logic signed [15:0] OP1_X,
  input wire logic signed [15:0] REL1_X,
  input wire logic signed [15:0] OP2_X,
  input wire logic signed [15:0] REL2_X,
  input wire logic signed [15:0] OP1_Y,
  input wire logic signed [15:0] REL1_Y,
  input wire logic signed [15:0] OP2_Y,
  input wire logic signed [15:0] REL2_Y,
  input wire logic signed [15:0] OP1_Z,
  input wire logic signed [15:0] REL1_Z,
  input wire logic signed [15:0] OP2_Z,
  input wire logic signed [15:0] REL2_Z,
  input wire logic RD_STB,
  input wire logic [7:0] RD_ADDR,
  input wire logic [1:0] RD_IDX,
  input wire logic SET_STB,
  input wire logic [7:0] SET_ADDR,
  output mgr_pkg::mgr_word_t RD_DATA,
  output logic RD_VALID,
  output mgr_pkg::mgr_word_t STATUS_OUT,
  output logic RESULT_READY
);
  import mgr_pkg::*;

  logic signed [RAW_W-1:0] raw [3];
  logic signed [RAW_W-1:0] lim_max [3];
  logic signed [RAW_W-1:0] lim_min [3];
  logic signed [15:0] op1 [3];
  logic signed [15:0] rel1 [3];
  logic signed [15:0] op2 [3];
  logic signed [15:0] rel2 [3];
  logic signed [15:0] result [3];
  logic [2:0] over;
  logic [2:0] sw1;
  logic [2:0] sw2;
  logic result_ready_flag;
  logic result_overrun_flag;
  logic sensor_overflow_flag;
  logic converter_overflow_flag;
  logic meas_taken;
  logic continuous;
  logic axis_read;
  logic set_access;
  logic ready_clear;
  mgr_word_t status_word;
  mgr_word_t identification_word;

  // per-axis inputs gathered for the generate loop
  assign raw[0] = MEAS_X;
  assign raw[1] = MEAS_Y;
  assign raw[2] = MEAS_Z;
  assign op1[0] = OP1_X;
  assign op1[1] = OP1_Y;
  assign op1[2] = OP1_Z;
  assign rel1[0] = REL1_X;
  assign rel1[1] = REL1_Y;
  assign rel1[2] = REL1_Z;
  assign op2[0] = OP2_X;
  assign op2[1] = OP2_Y;
  assign op2[2] = OP2_Z;
  assign rel2[0] = REL2_X;
  assign rel2[1] = REL2_Y;
  assign rel2[2] = REL2_Z;

  // mode decode: power-down ignores results, codes above single are continuous
  assign meas_taken = MEAS_STB && (MODE != MGR_PWR_DOWN);
  assign continuous = (MODE != MGR_PWR_DOWN) && (MODE != MGR_SINGLE);

  // one axis slice each; x and y shrink in wide range, z never does
  for (genvar g = 0; g < 3; g++) begin : g_axis
    if (g < 2) begin : g_xy
      assign lim_max[g] = WIDE_RANGE ? `MGR_WIDE_MAX : `MGR_FULL_MAX; // R12
      assign lim_min[g] = WIDE_RANGE ? `MGR_WIDE_MIN : `MGR_FULL_MIN; // R11
    end else begin : g_z
      assign lim_max[g] = `MGR_FULL_MAX; // R13
      assign lim_min[g] = `MGR_FULL_MIN; // R13
    end
    mgr_axis #(
      .RAW_W(RAW_W)
    ) u_axis (
      .clk(SYS_CLK),
      .rst(RESET), // R15
      .meas_stb(meas_taken),
      .raw(raw[g]),
      .lim_max(lim_max[g]),
      .lim_min(lim_min[g]),
      .op1(op1[g]),
      .rel1(rel1[g]),
      .op2(op2[g]),
      .rel2(rel2[g]),
      .result(result[g]),
      .over(over[g]),
      .sw1(sw1[g]),
      .sw2(sw2[g])
    );
  end

  // setting register window that also drops the ready flag
  assign set_access = SET_STB && (SET_ADDR >= `MGR_ADDR_SET_LO)
                      && (SET_ADDR <= `MGR_ADDR_SET_HI);
  assign ready_clear = axis_read || set_access; // R3

  // ready flag, a new result wins over a clear in the same cycle
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      result_ready_flag <= 1'b0; // R14
    end else if (meas_taken) begin
      result_ready_flag <= 1'b1; // R2
    end else if (ready_clear) begin
      result_ready_flag <= 1'b0; // R3
    end
  end

  // overrun: unread result replaced; recomputed at each measurement
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      result_overrun_flag <= 1'b0;
    end else if (meas_taken) begin
      result_overrun_flag <= continuous && result_ready_flag && !ready_clear; // R4 R5
    end
  end

  // sensor overflow: x or y out of range at the last measurement
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      sensor_overflow_flag <= 1'b0;
    end else if (meas_taken) begin
      sensor_overflow_flag <= over[0] || over[1]; // R8 R17
    end
  end

  // converter overflow reported with each measurement
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      converter_overflow_flag <= 1'b0;
    end else if (meas_taken) begin
      converter_overflow_flag <= MEAS_ADC_OVF; // R9
    end
  end

  // status and identification words
  assign status_word = {`MGR_ST_ONES, result_overrun_flag, converter_overflow_flag, // R16
                        sensor_overflow_flag, sw2[2], sw1[2], sw2[1], sw1[1],
                        sw2[0], sw1[0], result_ready_flag};
  assign identification_word = {MAKER_CODE, PART_CODE}; // R1

  // read path; there is no write path into these read-only words
  mgr_rdmux u_rdmux (
    .clk(SYS_CLK),
    .rst(RESET),
    .rd_stb(RD_STB),
    .addr(RD_ADDR),
    .idx(RD_IDX),
    .id_word(identification_word),
    .status(status_word), // R14
    .res_x(result[0]), // R10
    .res_y(result[1]),
    .res_z(result[2]),
    .rd_data(RD_DATA),
    .rd_valid(RD_VALID),
    .is_axis(axis_read)
  );

  assign STATUS_OUT = status_word;
  assign RESULT_READY = result_ready_flag;

  // checks
  sequence s_meas;
    meas_taken;
  endsequence

  sequence s_unread_replaced;
    meas_taken && continuous && result_ready_flag && !ready_clear;
  endsequence

  property p_ready_set;
    @(posedge SYS_CLK) disable iff (RESET)
    s_meas |=> result_ready_flag;
  endproperty
  a_ready_set: assert property (p_ready_set) else $error("ready not set"); // R2

  property p_ready_clr;
    @(posedge SYS_CLK) disable iff (RESET)
    (ready_clear && !meas_taken) |=> !result_ready_flag;
  endproperty
  a_ready_clr: assert property (p_ready_clr) else $error("ready not cleared"); // R3

  property p_set_clr;
    @(posedge SYS_CLK) disable iff (RESET)
    (SET_STB && SET_ADDR == `MGR_ADDR_SET_HI && !meas_taken) |=> !RESULT_READY;
  endproperty
  a_set_clr: assert property (p_set_clr) else $error("setting access kept ready"); // R3

  property p_ovr_set;
    @(posedge SYS_CLK) disable iff (RESET)
    s_unread_replaced |=> result_overrun_flag ##1 (result_overrun_flag || $past(meas_taken));
  endproperty
  a_ovr_set: assert property (p_ovr_set) else $error("overrun missed"); // R4

  property p_ovr_clr;
    @(posedge SYS_CLK) disable iff (RESET)
    (s_meas and !result_ready_flag) |=> !result_overrun_flag;
  endproperty
  a_ovr_clr: assert property (p_ovr_clr) else $error("overrun not cleared"); // R5

  property p_wide_clamp;
    @(posedge SYS_CLK) disable iff (RESET)
    (meas_taken && WIDE_RANGE && MEAS_X > $signed(`MGR_WIDE_MAX))
      |=> sensor_overflow_flag && result[0] == 16'h2c00;
  endproperty
  a_wide_clamp: assert property (p_wide_clamp) else $error("x not clamped"); // R12

  property p_sens_zero;
    @(posedge SYS_CLK) disable iff (RESET)
    (meas_taken && !over[0] && !over[1]) |=> !sensor_overflow_flag;
  endproperty
  a_sens_zero: assert property (p_sens_zero) else $error("overflow flag stuck"); // R8

  property p_adc;
    @(posedge SYS_CLK) disable iff (RESET)
    s_meas |=> converter_overflow_flag == $past(MEAS_ADC_OVF);
  endproperty
  a_adc: assert property (p_adc) else $error("adc flag wrong"); // R9

  property p_id_read;
    @(posedge SYS_CLK) disable iff (RESET)
    (RD_STB && RD_ADDR == `MGR_ADDR_ID && RD_IDX == 2'd0)
      |=> RD_VALID && RD_DATA == {MAKER_CODE, PART_CODE};
  endproperty
  a_id_read: assert property (p_id_read) else $error("identification wrong"); // R1

  property p_st_read;
    @(posedge SYS_CLK) disable iff (RESET)
    (RD_STB && RD_ADDR[7:4] == 4'h1 && RD_IDX == 2'd0) |=> RD_DATA == $past(status_word);
  endproperty
  a_st_read: assert property (p_st_read) else $error("status read wrong"); // R14

  property p_st_ones;
    @(posedge SYS_CLK) disable iff (RESET)
    $rose(result_ready_flag) |-> STATUS_OUT[15:10] == `MGR_ST_ONES;
  endproperty
  a_st_ones: assert property (p_st_ones) else $error("status top bits wrong"); // R16

  property p_result_hold;
    @(posedge SYS_CLK) disable iff (RESET)
    !meas_taken |=> $stable(result[2]) && $stable(result[1]) && $stable(result[0]);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result changed"); // R18

  property p_x_read;
    @(posedge SYS_CLK) disable iff (RESET)
    (RD_STB && RD_ADDR == `MGR_ADDR_ST_HI && RD_IDX == 2'd3 && !meas_taken)
      |=> RD_DATA == result[0] ##1 !result_ready_flag || $past(meas_taken);
  endproperty
  a_x_read: assert property (p_x_read) else $error("x read wrong"); // R10

  property p_y_clamp;
    @(posedge SYS_CLK) disable iff (RESET)
    (meas_taken && WIDE_RANGE && MEAS_Y < $signed(`MGR_WIDE_MIN))
      |=> sensor_overflow_flag && result[1] == 16'hd400;
  endproperty
  a_y_clamp: assert property (p_y_clamp) else $error("y not clamped"); // R12

  property p_pdown_ignore;
    @(posedge SYS_CLK) disable iff (RESET)
    (MEAS_STB && MODE == MGR_PWR_DOWN && !ready_clear)
      |=> $stable(result_ready_flag) && $stable(result[0]) && $stable(converter_overflow_flag);
  endproperty
  a_pdown_ignore: assert property (p_pdown_ignore) else $error("power-down result taken"); // R2
endmodule : mgr_readout

//--- sim/mgr_host_model.sv
// host model issuing register reads and setting accesses
`timescale 1ns/1ps
module mgr_host_model (
  input wire logic clk,
  input wire logic rd_valid,
  input wire mgr_pkg::mgr_word_t rd_data,
  output logic rd_stb,
  output logic [7:0] rd_addr,
  output logic [1:0] rd_idx,
  output logic set_stb,
  output logic [7:0] set_addr
);
  import mgr_pkg::*;
  // idle request lines
  initial begin
    rd_stb = 1'b0;
    rd_addr = 8'h00;
    rd_idx = 2'h0;
    set_stb = 1'b0;
    set_addr = 8'h00;
  end
  // one read; answer taken one cycle after the request edge
  task rd(input logic [7:0] a, input logic [1:0] i, output mgr_word_t d, output logic ok);
    @(posedge clk);
    rd_stb <= 1'b1;
    rd_addr <= a;
    rd_idx <= i;
    @(posedge clk);
    rd_stb <= 1'b0;
    rd_addr <= ~a; // released lines show a changed pattern
    rd_idx <= ~i;
    #1;
    ok = rd_valid;
    d = rd_data;
  endtask : rd
  // one setting access
  task set(input logic [7:0] a);
    @(posedge clk);
    set_stb <= 1'b1;
    set_addr <= a;
    @(posedge clk);
    set_stb <= 1'b0;
    set_addr <= ~a;
    #1;
  endtask : set
endmodule : mgr_host_model

//--- sim/mgr_readout_tb_top.sv
// self-checking testbench of the magnetometer readout
`timescale 1ns/1ps
module mgr_readout_tb_top;
  import mgr_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  mgr_mode_e mode = MGR_SINGLE;
  logic wide = 1'b0;
  logic meas_stb = 1'b0;
  logic signed [17:0] mx = '0;
  logic signed [17:0] my = '0;
  logic signed [17:0] mz = '0;
  logic adc = 1'b0;
  logic signed [15:0] t1o = 16'h0064;
  logic signed [15:0] t1r = 16'h0032;
  logic signed [15:0] t2o = 16'h03e8;
  logic signed [15:0] t2r = 16'h01f4;
  logic rd_stb, set_stb, rd_valid, ready;
  logic [7:0] rd_addr, set_addr;
  logic [1:0] rd_idx;
  mgr_word_t rd_data, status;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;

  always #4 sys_clk = ~sys_clk;

  mgr_readout i_mgr_readout (.SYS_CLK(sys_clk), .RESET(reset), .MODE(mode), .WIDE_RANGE(wide),
    .MEAS_STB(meas_stb), .MEAS_X(mx), .MEAS_Y(my), .MEAS_Z(mz), .MEAS_ADC_OVF(adc),
    .OP1_X(t1o), .REL1_X(t1r), .OP2_X(t2o), .REL2_X(t2r),
    .OP1_Y(t1o), .REL1_Y(t1r), .OP2_Y(t2o), .REL2_Y(t2r),
    .OP1_Z(t1o), .REL1_Z(t1r), .OP2_Z(t2o), .REL2_Z(t2r),
    .RD_STB(rd_stb), .RD_ADDR(rd_addr), .RD_IDX(rd_idx), .SET_STB(set_stb),
    .SET_ADDR(set_addr), .RD_DATA(rd_data), .RD_VALID(rd_valid), .STATUS_OUT(status),
    .RESULT_READY(ready));

  mgr_host_model i_mgr_host_model (.clk(sys_clk), .rd_valid(rd_valid), .rd_data(rd_data),
    .rd_stb(rd_stb), .rd_addr(rd_addr), .rd_idx(rd_idx), .set_stb(set_stb),
    .set_addr(set_addr));

  // verdict and end of run
  task finish_test();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  // hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      finish_test();
    end
  end

  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask : chk

  // status word and ready output together
  task st(input logic [15:0] e);
    chk("status", e, status);
    chk("ready", {15'h0, e[0]}, {15'h0, ready});
  endtask : st

  // read with fixed one-cycle answer
  task rdc(input logic [7:0] a, input logic [1:0] i, input mgr_word_t e);
    mgr_word_t d;
    logic v;
    i_mgr_host_model.rd(a, i, d, v);
    chk("rd_valid", 16'h0001, {15'h0, v});
    chk("rd_data", e, d);
  endtask : rdc

  // one finished measurement
  task meas(input logic signed [17:0] x, y, z, input logic ovf);
    @(posedge sys_clk);
    meas_stb <= 1'b1;
    mx <= x;
    my <= y;
    mz <= z;
    adc <= ovf;
    @(posedge sys_clk);
    meas_stb <= 1'b0;
    #1;
  endtask : meas

  task t_reset();
    st(16'hfc00);
    rdc(8'h00, 2'd0, 16'h3c5a);
    rdc(8'h00, 2'd1, 16'h0000);
    rdc(8'h17, 2'd1, 16'h0000);
  endtask : t_reset

  task t_status_addr();
    meas(18'h0_0005, 18'h0_0005, 18'h0_0005, 1'b0);
    for (int a = 16; a < 32; a++) begin
      rdc(a[7:0], 2'd0, 16'hfc01);
    end
    st(16'hfc01);
  endtask : t_status_addr

  task t_clamp_wide();
    wide <= 1'b1;
    meas(18'h0_2ee0, 18'h3_d120, 18'h0_9c40, 1'b0);
    st(16'hfce7);
    rdc(8'h17, 2'd1, 16'h7fff);
    st(16'hfce6);
    rdc(8'h17, 2'd2, 16'hd400);
    rdc(8'h1f, 2'd3, 16'h2c00);
  endtask : t_clamp_wide

  task t_full();
    wide <= 1'b0;
    meas(18'h3_63c0, 18'h0_7fff, 18'h3_8000, 1'b0);
    st(16'hfc99);
    rdc(8'h11, 2'd1, 16'h8000);
    rdc(8'h12, 2'd1, 16'h7fff);
    rdc(8'h14, 2'd1, 16'h8000);
  endtask : t_full

  task t_switch();
    meas(18'h0_00c8, 18'h0_00c8, 18'h0_00c8, 1'b0);
    st(16'hfc2b);
    meas(18'h0_07d0, 18'h0_07d0, 18'h0_07d0, 1'b0);
    st(16'hfc7f);
    meas(18'h0_0046, 18'h0_0046, 18'h0_0046, 1'b0);
    st(16'hfc2b);
    meas(18'h0_000a, 18'h0_000a, 18'h0_000a, 1'b0);
    st(16'hfc01);
  endtask : t_switch

  task t_overrun();
    mode <= MGR_CONT3;
    meas('0, '0, '0, 1'b0);
    st(16'hfe01);
    i_mgr_host_model.set(8'h30);
    st(16'hfe01);
    i_mgr_host_model.set(8'h27);
    st(16'hfe00);
    meas('0, '0, '0, 1'b1);
    st(16'hfd01);
    meas('0, '0, '0, 1'b0);
    st(16'hfe01);
  endtask : t_overrun

  task t_pdown_reset();
    mode <= MGR_PWR_DOWN;
    meas(18'h0_012c, 18'h0_012c, 18'h0_012c, 1'b0);
    i_mgr_host_model.set(8'h20);
    st(16'hfe00);
    rdc(8'h11, 2'd1, 16'h0000);
    mode <= MGR_SINGLE;
    meas(18'h0_012c, 18'h0_012c, 18'h0_012c, 1'b0);
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    #1;
    st(16'hfc00);
    rdc(8'h11, 2'd1, 16'h0000);
  endtask : t_pdown_reset

  // main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    #1;
    t_reset();
    t_status_addr();
    t_clamp_wide();
    t_full();
    t_switch();
    t_overrun();
    t_pdown_reset();
    finish_test();
  end
endmodule : mgr_readout_tb_top
